// File: include/io_fill_pkg.sv
/*
  Shared constants and types for the quad flash pin-level fill and idle logic.
  Assumes a single system clock domain; nothing here holds state.
*/
package io_fill_pkg;
  // 2-bit level selector choices for each data line
  typedef enum logic [1:0] {
    LVL_LOW  = 2'b00,
    LVL_HIGH = 2'b01,
    LVL_PREV = 2'b10,
    LVL_HIZ  = 2'b11
  } level_sel_t;

  // transfer width choice
  typedef enum logic [1:0] {
    WIDTH_1BIT = 2'b00,
    WIDTH_4BIT = 2'b10
  } width_t;

  localparam int          NUM_LINES      = 4;
  localparam logic [1:0]  IDLE_RST       = 2'b11;
  localparam logic [3:0]  LAST_VAL_RST   = 4'h0;
  localparam logic [3:0]  LAST_OE_RST    = 4'h0;
  localparam logic [3:0]  PIN_OUT_RST    = 4'h0;
  localparam logic [3:0]  PIN_OE_RST     = 4'h0;
  localparam logic        SEL_N_RST      = 1'b1;
  localparam logic [3:0]  PIN_IN_RST     = 4'h0;
endpackage

// File: include/line_drive_if.sv
/*
  Carries one data line's chosen level and enable between the selector leaf
  and the top. Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
interface line_drive_if;
  import io_fill_pkg::*;
  level_sel_t sel;
  logic       live_val;
  logic       live_oe;
  logic       last_val;
  logic       last_oe;
  logic       drv_val;
  logic       drv_oe;
  modport top  (output sel, output live_val, output live_oe, output last_val,
                output last_oe, input drv_val, input drv_oe);
  modport leaf (input sel, input live_val, input live_oe, input last_val,
                input last_oe, output drv_val, output drv_oe);
endinterface

// File: hw/line_level_sel.sv
/*
  Combinational selector for one data line: picks low, high, held last bit
  or float, or passes live transfer data. Assumes inputs are already synchronous.
*/
`timescale 1ns/1ps
module line_level_sel
(
  input wire logic  use_live,
  line_drive_if.leaf drv
);
  import io_fill_pkg::*;

  // live data wins while the line carries transfer bits
  always_comb
  begin
    drv.drv_val = 1'b0;
    drv.drv_oe  = 1'b0;
    if (use_live)
    begin
      drv.drv_val = drv.live_val;
      drv.drv_oe  = drv.live_oe;
    end
    else
    begin
      case (drv.sel)
        LVL_LOW:
        begin
          drv.drv_val = 1'b0;
          drv.drv_oe  = 1'b1;
        end
        LVL_HIGH:
        begin
          drv.drv_val = 1'b1;
          drv.drv_oe  = 1'b1;
        end
        LVL_PREV:
        begin
          drv.drv_val = drv.last_val; // float again if it floated last time
          drv.drv_oe  = drv.last_oe;
        end
        default:
        begin
          drv.drv_val = 1'b0;
          drv.drv_oe  = 1'b0;
        end
      endcase
    end
  end
endmodule // line_level_sel

// File: hw/io_fill_level.sv
/*
  Pin-level control of the four flash data lines: idle levels while the
  select is negated and fill levels on unused lines in single-line transfers.
  Assumes a sequencer on ref_clk supplies per-line data, enables and phase.
*/
`timescale 1ns/1ps

// How it works
// R1: with select negated, line 0 follows its idle selector.
// R2: in one-line transfers, line 3 follows its fill selector.
// R3: in one-line transfers, line 2 follows its fill selector.
// R4: in one-line read data phases, line 0 follows its read fill selector.
// R5: software keeps line 0 read fill at float unless width is one line.
// R6: with select negated, lines 1 to 3 follow their own idle selectors.
// R7: transfer width is one or four lines, set by configuration.
// R8: in four-line transfers, fill selectors are ignored; lines carry data.
module io_fill_level
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   xfer_active,
  input  wire logic                   read_phase,
  input  wire io_fill_pkg::width_t    transfer_data_width,
  input  wire io_fill_pkg::level_sel_t idle_level_line0,
  input  wire io_fill_pkg::level_sel_t idle_level_line1,
  input  wire io_fill_pkg::level_sel_t idle_level_line2,
  input  wire io_fill_pkg::level_sel_t idle_level_line3,
  input  wire io_fill_pkg::level_sel_t fill_level_line3,
  input  wire io_fill_pkg::level_sel_t fill_level_line2,
  input  wire io_fill_pkg::level_sel_t read_fill_level_line0,
  input  wire logic [3:0]             tx_data,
  input  wire logic [3:0]             tx_oe,
  input  wire logic [3:0]             flash_data_in,
  output logic [3:0]                  flash_data_out,
  output logic [3:0]                  flash_data_oe,
  output logic                        slave_select_n,
  output logic [3:0]                  rx_data
);
  import io_fill_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state
  logic [3:0] sync1_r, sync1_nxt;
  logic [3:0] rx_r, rx_nxt;
  logic [3:0] last_val_r, last_val_nxt;
  logic [3:0] last_oe_r, last_oe_nxt;
  logic [3:0] out_r, out_nxt;
  logic [3:0] oe_r, oe_nxt;
  logic       sel_n_r, sel_n_nxt;
  logic [3:0] use_live;
  logic [3:0] drv_val;
  logic [3:0] drv_oe;
  level_sel_t sel_of [NUM_LINES];
  logic       one_line;

  assign one_line = (transfer_data_width == WIDTH_1BIT); // R7

  //////////////////////////////////////////////////////////////////////////
  // per-line selector choice
  always_comb
  begin
    for (int i = 0; i < NUM_LINES; i++)
    begin
      sel_of[i]   = LVL_HIZ;
      use_live[i] = 1'b1; // R8
    end
    if (!xfer_active)
    begin
      // idle: every line takes its own idle setting
      sel_of[0]   = idle_level_line0; // R1
      sel_of[1]   = idle_level_line1; // R6
      sel_of[2]   = idle_level_line2; // R6
      sel_of[3]   = idle_level_line3; // R6
      use_live    = 4'h0;
    end
    else if (one_line)
    begin
      // lines 2 and 3 are unused in one-line mode
      sel_of[2]   = fill_level_line2; // R3
      sel_of[3]   = fill_level_line3; // R2
      use_live[2] = 1'b0;
      use_live[3] = 1'b0;
      if (read_phase)
      begin
        // line 0 is idle during one-line read; software keeps it float otherwise
        sel_of[0]   = read_fill_level_line0; // R4
        use_live[0] = 1'b0;
      end
    end
    // four-line: all lines stay live and the fill settings are ignored
  end

  //////////////////////////////////////////////////////////////////////////
  // one selector leaf per line
  generate
    for (genvar g = 0; g < NUM_LINES; g++)
    begin : g_line
      line_drive_if ld ();
      assign ld.sel      = sel_of[g];
      assign ld.live_val = tx_data[g];
      assign ld.live_oe  = tx_oe[g];
      assign ld.last_val = last_val_r[g];
      assign ld.last_oe  = last_oe_r[g];
      assign drv_val[g]  = ld.drv_val;
      assign drv_oe[g]   = ld.drv_oe;
      line_level_sel u_sel
      (
        .use_live (use_live[g]),
        .drv      (ld)
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // next values; last bit only tracks live transfer bits so idle can hold it
  always_comb
  begin
    sync1_nxt    = flash_data_in;
    rx_nxt       = sync1_r;
    out_nxt      = drv_val;
    oe_nxt       = drv_oe;
    sel_n_nxt    = ~xfer_active;
    last_val_nxt = last_val_r;
    last_oe_nxt  = last_oe_r;
    for (int i = 0; i < NUM_LINES; i++)
    begin
      if (xfer_active && use_live[i])
      begin
        last_val_nxt[i] = tx_data[i];
        last_oe_nxt[i]  = tx_oe[i];
      end
    end
  end

  // registers only; pins come from flops to avoid glitches on the flash
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_r    <= PIN_IN_RST;
      rx_r       <= PIN_IN_RST;
      out_r      <= PIN_OUT_RST;
      oe_r       <= PIN_OE_RST;
      sel_n_r    <= SEL_N_RST;
      last_val_r <= LAST_VAL_RST;
      last_oe_r  <= LAST_OE_RST;
    end
    else
    begin
      sync1_r    <= sync1_nxt;
      rx_r       <= rx_nxt;
      out_r      <= out_nxt;
      oe_r       <= oe_nxt;
      sel_n_r    <= sel_n_nxt;
      last_val_r <= last_val_nxt;
      last_oe_r  <= last_oe_nxt;
    end
  end

  assign flash_data_out = out_r;
  assign flash_data_oe  = oe_r;
  assign slave_select_n = sel_n_r;
  assign rx_data        = rx_r;

  //////////////////////////////////////////////////////////////////////////
  // checks: idle levels while the select is negated
  a_idle_line0_low: assert property (@(posedge ref_clk) disable iff (rst) // R1
    !xfer_active && idle_level_line0 == LVL_LOW |=> flash_data_oe[0] && !flash_data_out[0])
    else $error("line 0 idle low not driven");
  a_idle_select_off: assert property (@(posedge ref_clk) disable iff (rst) // R1
    !xfer_active |=> slave_select_n)
    else $error("select not negated while idle");
  a_idle_line1_hiz: assert property (@(posedge ref_clk) disable iff (rst) // R6
    !xfer_active && idle_level_line1 == LVL_HIZ |=> !flash_data_oe[1])
    else $error("line 1 idle float not honoured");
  a_idle_line3_high: assert property (@(posedge ref_clk) disable iff (rst) // R6
    !xfer_active && idle_level_line3 == LVL_HIGH |=> flash_data_oe[3] && flash_data_out[3])
    else $error("line 3 idle high not driven");
  // hold-previous must replay the last live bit, float included
  a_idle_prev_hold: assert property (@(posedge ref_clk) disable iff (rst) // R6
    xfer_active && one_line ##1 !xfer_active && idle_level_line1 == LVL_PREV
    |=> flash_data_oe[1] == $past(tx_oe[1], 2) && flash_data_out[1] == $past(tx_data[1], 2))
    else $error("line 1 idle hold lost last bit");

  //////////////////////////////////////////////////////////////////////////
  // checks: fill levels on unused lines in one-line transfers
  a_fill_line3_high: assert property (@(posedge ref_clk) disable iff (rst) // R2
    xfer_active && one_line && fill_level_line3 == LVL_HIGH
    |=> flash_data_oe[3] && flash_data_out[3])
    else $error("line 3 fill high not driven");
  a_fill_line3_hiz: assert property (@(posedge ref_clk) disable iff (rst) // R2
    xfer_active && one_line && fill_level_line3 == LVL_HIZ |=> !flash_data_oe[3])
    else $error("line 3 fill float not honoured");
  a_fill_line2_low: assert property (@(posedge ref_clk) disable iff (rst) // R3
    xfer_active && one_line && fill_level_line2 == LVL_LOW
    |=> flash_data_oe[2] && !flash_data_out[2])
    else $error("line 2 fill low not driven");
  a_fill_line2_high: assert property (@(posedge ref_clk) disable iff (rst) // R3
    xfer_active && one_line && fill_level_line2 == LVL_HIGH
    |=> flash_data_oe[2] && flash_data_out[2])
    else $error("line 2 fill high not driven");
  a_rdfill_line0: assert property (@(posedge ref_clk) disable iff (rst) // R4
    xfer_active && one_line && read_phase && read_fill_level_line0 == LVL_HIZ
    |=> !flash_data_oe[0])
    else $error("line 0 read fill float not honoured");
  a_rdfill_line0_low: assert property (@(posedge ref_clk) disable iff (rst) // R4
    xfer_active && one_line && read_phase && read_fill_level_line0 == LVL_LOW
    |=> flash_data_oe[0] && !flash_data_out[0])
    else $error("line 0 read fill low not driven");
  // width taken straight from the port, so a bad one_line decode shows up here
  a_width_one_fill: assert property (@(posedge ref_clk) disable iff (rst) // R7
    xfer_active && transfer_data_width == WIDTH_1BIT && fill_level_line2 == LVL_HIZ
    |=> !flash_data_oe[2])
    else $error("one-line width did not apply line 2 fill");

  //////////////////////////////////////////////////////////////////////////
  // checks: live data and select during transfers
  a_quad_live: assert property (@(posedge ref_clk) disable iff (rst) // R8
    xfer_active && !one_line |=> flash_data_oe == $past(tx_oe)
    && flash_data_out == $past(tx_data))
    else $error("quad transfer lines not live");
  a_select_follows: assert property (@(posedge ref_clk) disable iff (rst) // R1
    xfer_active |=> !slave_select_n)
    else $error("select not asserted in transfer");
endmodule // io_fill_level

// File: dv/flash_model.sv
/*
  Flash partner: drives read data while selected in a read phase.
  Assumes the bench resolves the pins from the controller's enables only.
*/
`timescale 1ns/1ps
module flash_model
(
  input  wire logic       ref_clk,
  input  wire logic       slave_select_n,
  input  wire logic       read_phase,
  input  wire logic       wide,
  output logic [3:0]      q
);
  localparam logic [3:0] RD_DATA = 4'h6;
  logic [3:0] pat_r = 4'h3;
  logic [3:0] q_oe;
  // released lines flip each cycle, so a stale level never passes as data
  always @(posedge ref_clk) pat_r <= ~pat_r;
  assign q_oe = (!slave_select_n && read_phase) ? (wide ? 4'hF : 4'h2) : 4'h0;
  assign q    = (q_oe & RD_DATA) | (~q_oe & pat_r);
endmodule // flash_model

// File: dv/io_fill_level_bench.sv
/*
  Bench for the idle and fill level logic of the four flash lines.
  Assumes a 100 MHz ref_clk and the flash partner model.
*/
`timescale 1ns/1ps
module io_fill_level_bench;
  import io_fill_pkg::*;
  logic       ref_clk = 1'b0, rst = 1'b1, xfer = 1'b0, rd = 1'b0, sel_n;
  width_t     width = WIDTH_1BIT;
  level_sel_t id0 = LVL_HIZ, id1 = LVL_HIZ, id2 = LVL_HIZ, id3 = LVL_HIZ;
  level_sel_t f3 = LVL_HIZ, f2 = LVL_HIZ, rf0 = LVL_HIZ;
  logic [3:0] txd = 4'h0, txe = 4'h0, pin_in, f_q, out, oe, rx;
  int         mismatches = 0, tests_run = 0;
  // pin level: our drive wins, else the flash side
  assign pin_in = (oe & out) | (~oe & f_q);
  initial forever #5 ref_clk = ~ref_clk;
  io_fill_level dut (.ref_clk(ref_clk), .rst(rst), .xfer_active(xfer), .read_phase(rd),
    .transfer_data_width(width), .idle_level_line0(id0), .idle_level_line1(id1),
    .idle_level_line2(id2), .idle_level_line3(id3), .fill_level_line3(f3),
    .fill_level_line2(f2), .read_fill_level_line0(rf0), .tx_data(txd), .tx_oe(txe),
    .flash_data_in(pin_in), .flash_data_out(out), .flash_data_oe(oe),
    .slave_select_n(sel_n), .rx_data(rx));
  flash_model flash (.ref_clk(ref_clk), .slave_select_n(sel_n), .read_phase(rd),
    .wide(width == WIDTH_4BIT), .q(f_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // value compared only where driven; floating lines carry no meaning
  // returns on a rising edge so the next stimulus lands on the edge
  task automatic pins(input logic [3:0] eo, input logic [3:0] ev, input logic en);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("oe", eo, oe);
    chk("out", ev & eo, out & oe);
    chk("sel_n", {3'h0, en}, {3'h0, sel_n});
    @(posedge ref_clk);
  endtask
  task automatic go(input logic x, input logic r, input width_t w, input logic [3:0] e);
    @(posedge ref_clk);
    xfer  <= x;
    rd    <= r;
    width <= w;
    txe   <= e;
  endtask
  task automatic idle_all(input level_sel_t s);
    id0 <= s;
    id1 <= s;
    id2 <= s;
    id3 <= s;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    level_sel_t s[3] = '{LVL_LOW, LVL_HIGH, LVL_HIZ};
    idle_all(LVL_PREV);
    pins(4'h0, 4'h0, 1'b1);
    foreach (s[i])
    begin
      idle_all(s[i]);
      pins({4{s[i] != LVL_HIZ}}, {4{s[i] == LVL_HIGH}}, 1'b1);
    end
    id0 <= LVL_LOW;
    id1 <= LVL_HIGH;
    id3 <= LVL_HIGH;
    pins(4'hB, 4'hA, 1'b1);
    $display("test idle done");
  endtask
  task automatic t_single();
    level_sel_t s[3] = '{LVL_LOW, LVL_HIGH, LVL_HIZ};
    txd <= 4'h1;
    go(1'b1, 1'b0, WIDTH_1BIT, 4'h1);
    foreach (s[i])
    begin
      f3 <= s[i];
      f2 <= (s[i] == LVL_HIGH) ? LVL_LOW : LVL_HIGH;
      pins({s[i] != LVL_HIZ, 3'b101}, {s[i] == LVL_HIGH, s[i] != LVL_HIGH, 2'b01}, 1'b0);
    end
    go(1'b0, 1'b0, WIDTH_1BIT, 4'h0);
    idle_all(LVL_PREV);
    pins(4'h1, 4'h1, 1'b1);
    $display("test single done");
  endtask
  task automatic t_read();
    level_sel_t s[3] = '{LVL_LOW, LVL_HIGH, LVL_HIZ};
    f3 <= LVL_HIZ;
    f2 <= LVL_HIZ;
    go(1'b1, 1'b1, WIDTH_1BIT, 4'h0);
    foreach (s[i])
    begin
      rf0 <= s[i];
      pins({3'h0, s[i] != LVL_HIZ}, {3'h0, s[i] == LVL_HIGH}, 1'b0);
      chk("rx line1", 4'h2, rx & 4'h2);
    end
    $display("test read done");
  endtask
  task automatic t_quad();
    txd <= 4'h5;
    f3  <= LVL_LOW;
    f2  <= LVL_HIGH;
    go(1'b1, 1'b0, WIDTH_4BIT, 4'hF);
    pins(4'hF, 4'h5, 1'b0);
    go(1'b0, 1'b0, WIDTH_4BIT, 4'h0);
    pins(4'hF, 4'h5, 1'b1);
    // lines 2 and 3 replay the last quad bits as fill
    f3 <= LVL_PREV;
    f2 <= LVL_PREV;
    go(1'b1, 1'b0, WIDTH_1BIT, 4'h0);
    pins(4'hC, 4'h4, 1'b0);
    rf0 <= LVL_HIZ;
    go(1'b1, 1'b1, WIDTH_4BIT, 4'h0);
    pins(4'h0, 4'h0, 1'b0);
    chk("rx", 4'h6, rx);
    $display("test quad done");
  endtask
  // mid-run reset must clear the held last bits, so hold-previous floats
  task automatic t_reset();
    go(1'b1, 1'b0, WIDTH_4BIT, 4'hF);
    go(1'b0, 1'b0, WIDTH_4BIT, 4'h0);
    rst <= 1'b1;
    pins(4'h0, 4'h0, 1'b1);
    rst <= 1'b0;
    pins(4'h0, 4'h0, 1'b1);
    $display("test reset done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // reset, then the scenarios in order
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_idle();
    t_single();
    t_read();
    t_quad();
    t_reset();
    finish_test();
  end
endmodule // io_fill_level_bench
